// [hw/eee_defs.svh]
// Purpose: offsets, field positions and reset values of the low-power-idle status group
// Assumes: Avalon-MM byte addresses are four times the printed register index
// Notes:   definitions only
`ifndef EEE_DEFS_SVH
`define EEE_DEFS_SVH

// register indices as printed; byte address is index times four
`define EEE_IDX_PCS_CTRL        16'h3000
`define EEE_IDX_PCS_LPI_STATUS  16'h3001
`define EEE_IDX_SPEED_CAP       16'h3014
`define EEE_IDX_WAKE_FAULT      16'h3016
`define EEE_IDX_LOCAL_ADV       16'h703c
`define EEE_IDX_PARTNER_ABILITY 16'h703d
`define EEE_IDX_EEE_CFG         16'h7f00
`define EEE_IDX_IRQ_STATUS      16'h7f01
`define EEE_IDX_IRQ_ENABLE      16'h7f02
`define EEE_IDX_IRQ_CLEAR       16'h7f03

// field positions
`define EEE_BIT_SOFT_RESET      15
`define EEE_BIT_TX_LPI          9
`define EEE_BIT_RX_LPI          8
`define EEE_BIT_TX_CLK_STOP     6
`define EEE_BIT_CAP_1000        2
`define EEE_BIT_CAP_100         1
`define EEE_BIT_ADV_100         1
`define EEE_BIT_LP_100          1
`define EEE_BIT_EEE_ENABLE      0

// reset values and the wake-fault counter saturation value
`define EEE_RST_TX_CLK_STOP     1'b1
`define EEE_RST_CAP_100         1'b1
`define EEE_RST_CAP_1000        1'b0
`define EEE_RST_WAKE_FAULT      16'h0000
`define EEE_RST_LP_100          1'b0
`define EEE_SAT_WAKE_FAULT      16'hffff

// interrupt status bits
`define EEE_IRQ_TX_LPI          0
`define EEE_IRQ_RX_LPI          1
`define EEE_IRQ_WAKE_FAULT      2
`define EEE_IRQ_LP_CHANGE       3
`define EEE_IRQ_WIDTH           4

`endif

// [hw/eee_lpi_status_registers.sv]
// Purpose: low-power-idle status, capability, wake-fault counter and advertisement registers
// Assumes: Avalon-MM slave, 32-bit words, byte address = index * 4, 25 MHz clock
// Notes:   lpi and partner indications arrive from other domains and are synchronised
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`include "eee_defs.svh"
module eee_lpi_status_registers (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [17:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        tx_lpi_active,
    input  wire logic        rx_lpi_active,
    input  wire logic        partner_eee_100,
    input  wire logic        wake_fault_pulse,
    input  wire logic        adv_strap,
    output logic             tx_clock_stoppable,
    output logic             advertise_eee_100,
    output logic             eee_negotiation_on,
    output logic             irq
);
    typedef struct packed {
        eee_pkg::eee_bus_state_t bus;
        logic [31:0] rdata;
        logic        wreq;
        logic        strap_taken;
        logic        adv_100;
        logic        eee_en;
        logic [15:0] wake_cnt;
        logic [3:0]  irq_stat;
        logic [3:0]  irq_en;
        logic [3:0]  prev;
        logic        wf_d;
        logic        tx_stop;
        logic        adv_out;
        logic        neg_on;
        logic        irq_q;
    } eee_regs_state_t;

    eee_regs_state_t st;
    eee_regs_state_t next_st;
    eee_sync_if      sio ();

    logic [15:0] word_idx;
    logic [15:0] wdata;
    logic        wr_lo;
    logic [3:0]  ev;
    logic        wf_event;
    logic [15:0] rd_mux;
    logic        rd_cnt_seen;
    logic        srst_seen;

    ////////////////////////////////////////////////////////////////////////////////
    // synchronise off-domain indications, the wake pulse included
    assign sio.raw = {wake_fault_pulse, partner_eee_100, rx_lpi_active, tx_lpi_active};

    eee_pin_sync u_sync (
        .clock  (clock),
        .resetn (resetn),
        .sio    (sio)
    );

    assign word_idx = avs_address[17:2];
    assign wdata    = avs_writedata[15:0];
    assign wr_lo    = avs_byteenable[0] & avs_byteenable[1];
    // one fault per rising edge of the synchronised pulse line
    assign wf_event = sio.stable[3] & ~st.wf_d;

    // events: lpi entry on either side, wake fault, partner ability change
    assign ev = {sio.stable[2] ^ st.prev[2], wf_event,
                 sio.stable[1] & ~st.prev[1], sio.stable[0] & ~st.prev[0]};

    // bus-side views of the counter clears, for the checks below
    assign rd_cnt_seen = (st.bus == eee_pkg::EEE_IDLE) && avs_read
                         && (word_idx == `EEE_IDX_WAKE_FAULT);
    assign srst_seen   = (st.bus == eee_pkg::EEE_WRITE) && wr_lo
                         && (word_idx == `EEE_IDX_PCS_CTRL) && wdata[`EEE_BIT_SOFT_RESET];

    ////////////////////////////////////////////////////////////////////////////////
    // read mux; everything not listed reads zero
    always_comb begin
        rd_mux = 16'h0000;
        case (word_idx)
            `EEE_IDX_PCS_CTRL: begin
                rd_mux = 16'h0000; // soft reset self-clears, reads 0
            end
            `EEE_IDX_PCS_LPI_STATUS: begin
                rd_mux[`EEE_BIT_TX_LPI]      = sio.stable[0];
                rd_mux[`EEE_BIT_RX_LPI]      = sio.stable[1];
                rd_mux[`EEE_BIT_TX_CLK_STOP] = `EEE_RST_TX_CLK_STOP;
            end
            `EEE_IDX_SPEED_CAP: begin
                rd_mux[`EEE_BIT_CAP_100]  = `EEE_RST_CAP_100;
                rd_mux[`EEE_BIT_CAP_1000] = `EEE_RST_CAP_1000;
            end
            `EEE_IDX_WAKE_FAULT: begin
                rd_mux = st.wake_cnt;
            end
            `EEE_IDX_LOCAL_ADV: begin
                rd_mux[`EEE_BIT_ADV_100] = st.adv_100;
            end
            `EEE_IDX_PARTNER_ABILITY: begin
                rd_mux[`EEE_BIT_LP_100] = sio.stable[2];
            end
            `EEE_IDX_EEE_CFG: begin
                rd_mux[`EEE_BIT_EEE_ENABLE] = st.eee_en;
            end
            `EEE_IDX_IRQ_STATUS: begin
                rd_mux[`EEE_IRQ_WIDTH-1:0] = st.irq_stat;
            end
            `EEE_IDX_IRQ_ENABLE: begin
                rd_mux[`EEE_IRQ_WIDTH-1:0] = st.irq_en;
            end
            default: begin
                rd_mux = 16'h0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic; waitrequest drops one cycle after the request is seen
    always_comb begin
        logic soft_rst;
        logic rd_cnt;
        logic [3:0] clr;
        soft_rst     = 1'b0;
        rd_cnt       = 1'b0;
        clr          = 4'h0;
        next_st      = st;
        next_st.prev = sio.stable;
        next_st.wf_d = sio.stable[3];
        // strap caught on the first clock after reset release
        if (!st.strap_taken) begin
            next_st.strap_taken = 1'b1;
            next_st.adv_100     = adv_strap;
        end
        case (st.bus)
            eee_pkg::EEE_IDLE: begin
                next_st.wreq = 1'b1;
                if (avs_read) begin
                    next_st.bus   = eee_pkg::EEE_READ;
                    next_st.rdata = {16'h0000, rd_mux};
                    next_st.wreq  = 1'b0;
                    // clear in the capture cycle so a fault arriving later is kept
                    rd_cnt        = (word_idx == `EEE_IDX_WAKE_FAULT);
                end else if (avs_write) begin
                    next_st.bus  = eee_pkg::EEE_WRITE;
                    next_st.wreq = 1'b0;
                end
            end
            eee_pkg::EEE_READ: begin
                // answer cycle; data was captured on the take edge
                next_st.bus  = eee_pkg::EEE_IDLE;
                next_st.wreq = 1'b1;
            end
            eee_pkg::EEE_WRITE: begin
                next_st.bus  = eee_pkg::EEE_IDLE;
                next_st.wreq = 1'b1;
                if (wr_lo) begin
                    case (word_idx)
                        `EEE_IDX_PCS_CTRL: begin
                            soft_rst = wdata[`EEE_BIT_SOFT_RESET];
                        end
                        `EEE_IDX_LOCAL_ADV: begin
                            next_st.adv_100 = wdata[`EEE_BIT_ADV_100];
                        end
                        `EEE_IDX_EEE_CFG: begin
                            next_st.eee_en = wdata[`EEE_BIT_EEE_ENABLE];
                        end
                        `EEE_IDX_IRQ_ENABLE: begin
                            next_st.irq_en = wdata[`EEE_IRQ_WIDTH-1:0];
                        end
                        `EEE_IDX_IRQ_CLEAR: begin
                            clr = wdata[`EEE_IRQ_WIDTH-1:0];
                        end
                        default: begin
                            clr = 4'h0;
                        end
                    endcase
                end
            end
            default: begin
                next_st.bus  = eee_pkg::EEE_IDLE;
                next_st.wreq = 1'b1;
            end
        endcase
        // wake-fault counter: clear, then count with saturation; a fault in the
        // clearing cycle is kept so no event is lost
        if (soft_rst || rd_cnt) begin
            next_st.wake_cnt = wf_event ? 16'h0001 : `EEE_RST_WAKE_FAULT;
        end else if (wf_event && st.wake_cnt != `EEE_SAT_WAKE_FAULT) begin
            next_st.wake_cnt = st.wake_cnt + 16'h0001;
        end
        // soft reset reloads only the advertisement from the strap; eee enable and irq enable and status keep their values
        if (soft_rst) begin
            next_st.adv_100 = adv_strap;
        end
        // set wins over clear
        next_st.irq_stat = (st.irq_stat & ~clr) | ev;
        next_st.irq_q    = |(next_st.irq_stat & next_st.irq_en);
        next_st.tx_stop  = `EEE_RST_TX_CLK_STOP;
        // negotiation ignores advertisement when the feature is off
        next_st.adv_out  = next_st.adv_100 & next_st.eee_en;
        next_st.neg_on   = next_st.eee_en;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st             <= '0;
            st.bus         <= eee_pkg::EEE_IDLE;
            st.adv_100     <= 1'b1;
            st.eee_en      <= 1'b1;
            st.tx_stop     <= `EEE_RST_TX_CLK_STOP;
            st.wreq        <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata       = st.rdata;
    assign avs_waitrequest    = st.wreq;
    assign tx_clock_stoppable = st.tx_stop;
    assign advertise_eee_100  = st.adv_out;
    assign eee_negotiation_on = st.neg_on;
    assign irq                = st.irq_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    AST_SAT: assert property (@(posedge clock) disable iff (!resetn)
        st.wake_cnt == `EEE_SAT_WAKE_FAULT && !rd_cnt_seen && !srst_seen
        |=> st.wake_cnt == `EEE_SAT_WAKE_FAULT)
        else $error("counter wrapped");
    AST_RDCLR: assert property (@(posedge clock) disable iff (!resetn)
        rd_cnt_seen && !wf_event |=> st.wake_cnt == 16'h0000)
        else $error("counter not cleared by read");
    AST_INC: assert property (@(posedge clock) disable iff (!resetn)
        wf_event && !rd_cnt_seen && !srst_seen && st.wake_cnt != `EEE_SAT_WAKE_FAULT
        |=> st.wake_cnt == $past(st.wake_cnt) + 16'h0001)
        else $error("fault not counted");
    AST_TXSTOP: assert property (@(posedge clock) disable iff (!resetn)
        tx_clock_stoppable == 1'b1)
        else $error("clock stop permission lost");
    AST_STAT: assert property (@(posedge clock) disable iff (!resetn)
        st.bus == eee_pkg::EEE_IDLE && avs_read && word_idx == `EEE_IDX_PCS_LPI_STATUS
        |=> avs_readdata[`EEE_BIT_TX_LPI] == $past(sio.stable[0])
            && avs_readdata[`EEE_BIT_RX_LPI] == $past(sio.stable[1]) && !avs_waitrequest)
        else $error("lpi status mismatch");
    AST_CAP: assert property (@(posedge clock) disable iff (!resetn)
        st.bus == eee_pkg::EEE_IDLE && avs_read && word_idx == `EEE_IDX_SPEED_CAP
        |=> avs_readdata == 32'h0000_0002)
        else $error("capability word wrong");
    AST_RSVD: assert property (@(posedge clock) disable iff (!resetn)
        avs_readdata[31:16] == 16'h0000)
        else $error("upper bits not zero");
    AST_IGN: assert property (@(posedge clock) disable iff (!resetn)
        !st.eee_en |-> !advertise_eee_100)
        else $error("advertised while disabled");
    AST_SRST: assert property (@(posedge clock) disable iff (!resetn)
        st.bus == eee_pkg::EEE_WRITE && wr_lo && word_idx == `EEE_IDX_PCS_CTRL
        && wdata[15] && !wf_event |=> st.wake_cnt == 16'h0000)
        else $error("soft reset left counter");
    // handshake: the answer cycle is a single clock
    AST_WREQ: assert property (@(posedge clock) disable iff (!resetn)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    // partner and advertisement reads carry the value seen on the take edge
    AST_PART: assert property (@(posedge clock) disable iff (!resetn)
        st.bus == eee_pkg::EEE_IDLE && avs_read && word_idx == `EEE_IDX_PARTNER_ABILITY
        |=> avs_readdata[`EEE_BIT_LP_100] == $past(sio.stable[2]))
        else $error("partner ability mismatch");
    AST_ADV: assert property (@(posedge clock) disable iff (!resetn)
        st.bus == eee_pkg::EEE_IDLE && avs_read && word_idx == `EEE_IDX_LOCAL_ADV
        |=> avs_readdata[`EEE_BIT_ADV_100] == $past(st.adv_100))
        else $error("advertisement mismatch");
    // soft reset reloads the advertisement from the strap
    AST_STRAP: assert property (@(posedge clock) disable iff (!resetn)
        srst_seen |=> st.adv_100 == $past(adv_strap))
        else $error("advertisement not reloaded");
endmodule // eee_lpi_status_registers

// [hw/eee_pin_sync.sv]
// Purpose: three-flop synchroniser with agreement filter for off-domain indications
// Assumes: inputs change slowly relative to the 40 ns clock
// Notes:   a change counts once the second and third stages agree
`timescale 1ns/1ps
module eee_pin_sync (
    input  wire logic clock,
    input  wire logic resetn,
    eee_sync_if.src   sio
);
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] q;
    } eee_sync_state_t;

    eee_sync_state_t st;
    eee_sync_state_t next_st;

    // first stage feeds only the second
    always_comb begin
        next_st    = st;
        next_st.s1 = sio.raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < 4; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sio.stable = st.q;
endmodule // eee_pin_sync

// [hw/eee_pkg.sv]
// Purpose: shared types of the low-power-idle status group
// Assumes: constants live in eee_defs.svh
// Notes:   types only
package eee_pkg;
    typedef enum logic [2:0] {
        EEE_IDLE  = 3'b001,
        EEE_READ  = 3'b010,
        EEE_WRITE = 3'b100
    } eee_bus_state_t;
endpackage

// [hw/eee_sync_if.sv]
// Purpose: carries sampled indications from the synchroniser to the register bank
// Assumes: one clock domain
// Notes:   plain bundle with two modports
`timescale 1ns/1ps
interface eee_sync_if;
    logic [3:0] raw;
    logic [3:0] stable;
    modport src (input raw, output stable);
    modport dst (output raw, input stable);
endinterface

// [verification/eee_far_end_model.sv]
// Purpose: behavioural stand-in for the mac and the remote link partner
// Assumes: commands come from the bench just after a rising edge
// Notes:   wake faults are pulses of four clocks high and four low, above the sync minimum
`timescale 1ns/1ps
module eee_far_end_model (
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       tx_lpi_req,
    input  wire logic       rx_lpi_req,
    input  wire logic       partner_req,
    input  wire logic [7:0] fault_req,
    input  wire logic       fault_go,
    input  wire logic       tx_clock_stoppable,
    output logic            tx_lpi_active,
    output logic            rx_lpi_active,
    output logic            partner_eee_100,
    output logic            wake_fault_pulse,
    output logic            fault_busy,
    output logic            mac_clock_stopped
);
    logic [7:0] left;
    logic [2:0] phase;

    ////////////////////////////////////////////////////////////////////////////////
    // idle indications and partner ability are plain levels
    assign tx_lpi_active   = tx_lpi_req;
    assign rx_lpi_active   = rx_lpi_req;
    assign partner_eee_100 = partner_req;
    assign fault_busy      = (left != 8'h00) || wake_fault_pulse;

    ////////////////////////////////////////////////////////////////////////////////
    // late-wake pulse train; a new burst is only accepted when idle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            left              <= 8'h00;
            phase             <= 3'h0;
            wake_fault_pulse  <= 1'b0;
            mac_clock_stopped <= 1'b0;
        end else begin
            // mac halts its clock only while idling and permitted
            mac_clock_stopped <= tx_lpi_req && tx_clock_stoppable;
            if (fault_go && left == 8'h00) begin
                left  <= fault_req;
                phase <= 3'h0;
            end else if (left != 8'h00) begin
                phase            <= phase + 3'h1;
                wake_fault_pulse <= (phase < 3'h4);
                if (phase == 3'h7) begin
                    left <= left - 8'h01;
                end
            end
        end
    end
endmodule // eee_far_end_model

// [verification/eee_lpi_status_registers_tb.sv]
// Purpose: self-checking bench for the low-power-idle status register group
// Assumes: avalon answer two edges after request, input sync latency four edges
// Notes:   counter saturation needs 65535 faults, too long for this run
`timescale 1ns/1ps
`include "eee_defs.svh"
module eee_lpi_status_registers_tb;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic [17:0] avs_address = 18'h00000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        tx_lpi_active, rx_lpi_active, partner_eee_100, wake_fault_pulse;
    logic        adv_strap = 1'b1;
    logic        tx_clock_stoppable, advertise_eee_100, eee_negotiation_on, irq;
    logic        tx_req = 1'b0, rx_req = 1'b0, p_req = 1'b0, fault_go = 1'b0;
    logic [7:0]  fault_req = 8'h00;
    logic        fault_busy;
    int          fail_count = 0;
    int          total_checks = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // 25 MHz reference present from power-on
    initial begin
        forever #20 clock = ~clock;
    end

    eee_lpi_status_registers uut (.clock(clock), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tx_lpi_active(tx_lpi_active), .rx_lpi_active(rx_lpi_active),
        .partner_eee_100(partner_eee_100), .wake_fault_pulse(wake_fault_pulse),
        .adv_strap(adv_strap), .tx_clock_stoppable(tx_clock_stoppable),
        .advertise_eee_100(advertise_eee_100), .eee_negotiation_on(eee_negotiation_on),
        .irq(irq));

    eee_far_end_model far (.clock(clock), .resetn(resetn), .tx_lpi_req(tx_req),
        .rx_lpi_req(rx_req), .partner_req(p_req), .fault_req(fault_req),
        .fault_go(fault_go), .tx_clock_stoppable(tx_clock_stoppable),
        .tx_lpi_active(tx_lpi_active), .rx_lpi_active(rx_lpi_active),
        .partner_eee_100(partner_eee_100), .wake_fault_pulse(wake_fault_pulse),
        .fault_busy(fault_busy), .mac_clock_stopped());

    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // one avalon transfer; starts on a fresh edge so release and next request never collide
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
                       input logic [3:0] be, output logic [31:0] rd);
        int n;
        @(posedge clock);
        avs_address    <= {idx, 2'b00};
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= {16'h0000, wd};
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, 4'hf, d);
    endtask

    task automatic expect_reg(input string what, input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 16'h0000, 4'hf, d);
        check(what, d, exp);
    endtask

    // produce late wakes and let them pass the synchroniser
    task automatic faults(input logic [7:0] k);
        int n;
        @(posedge clock);
        fault_req <= k;
        fault_go  <= 1'b1;
        @(posedge clock);
        fault_go <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (fault_busy !== 1'b0 && n < 5000);
        if (n >= 5000) begin
            fail_count++;
            print_verdict();
        end
        idle(6);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_reset_values();
        expect_reg("status", `EEE_IDX_PCS_LPI_STATUS, 32'h00000040);
        expect_reg("capability", `EEE_IDX_SPEED_CAP, 32'h00000002);
        expect_reg("wake count", `EEE_IDX_WAKE_FAULT, 32'h00000000);
        expect_reg("advertise", `EEE_IDX_LOCAL_ADV, 32'h00000002);
        expect_reg("partner", `EEE_IDX_PARTNER_ABILITY, 32'h00000000);
        expect_reg("unmapped", 16'h1234, 32'h00000000);
        check("clock stoppable", {31'h0, tx_clock_stoppable}, 32'h1);
        $display("test reset values done");
    endtask

    task automatic test_lpi_and_irq();
        @(posedge clock);
        tx_req <= 1'b1;
        idle(6);
        expect_reg("tx idle", `EEE_IDX_PCS_LPI_STATUS, 32'h00000240);
        tx_req <= 1'b0;
        rx_req <= 1'b1;
        idle(6);
        expect_reg("rx idle", `EEE_IDX_PCS_LPI_STATUS, 32'h00000140);
        rx_req <= 1'b0;
        idle(6);
        expect_reg("no idle", `EEE_IDX_PCS_LPI_STATUS, 32'h00000040);
        check("irq masked", {31'h0, irq}, 32'h0);
        expect_reg("irq status", `EEE_IDX_IRQ_STATUS, 32'h00000003);
        wr(`EEE_IDX_IRQ_STATUS, 16'h0000);
        expect_reg("irq status ro", `EEE_IDX_IRQ_STATUS, 32'h00000003);
        wr(`EEE_IDX_IRQ_ENABLE, 16'h0001);
        idle(2);
        check("irq raised", {31'h0, irq}, 32'h1);
        wr(`EEE_IDX_IRQ_CLEAR, 16'h0003);
        idle(2);
        check("irq cleared", {31'h0, irq}, 32'h0);
        expect_reg("irq status clr", `EEE_IDX_IRQ_STATUS, 32'h00000000);
        expect_reg("irq clear wo", `EEE_IDX_IRQ_CLEAR, 32'h00000000);
        wr(`EEE_IDX_IRQ_ENABLE, 16'h0000);
        $display("test lpi and irq done");
    endtask

    task automatic test_wake_counter();
        faults(8'h03);
        expect_reg("count three", `EEE_IDX_WAKE_FAULT, 32'h00000003);
        expect_reg("count cleared", `EEE_IDX_WAKE_FAULT, 32'h00000000);
        faults(8'h02);
        wr(`EEE_IDX_PCS_CTRL, 16'h8000);
        idle(2);
        expect_reg("count soft reset", `EEE_IDX_WAKE_FAULT, 32'h00000000);
        expect_reg("ctrl self clear", `EEE_IDX_PCS_CTRL, 32'h00000000);
        $display("test wake counter done");
    endtask

    task automatic test_advertise();
        logic [31:0] d;
        wr(`EEE_IDX_LOCAL_ADV, 16'h0000);
        idle(2);
        expect_reg("adv off", `EEE_IDX_LOCAL_ADV, 32'h00000000);
        check("adv pin off", {31'h0, advertise_eee_100}, 32'h0);
        bus(1'b1, `EEE_IDX_LOCAL_ADV, 16'h0002, 4'hc, d);
        expect_reg("adv lanes", `EEE_IDX_LOCAL_ADV, 32'h00000000);
        wr(`EEE_IDX_LOCAL_ADV, 16'hffff);
        expect_reg("adv reserved", `EEE_IDX_LOCAL_ADV, 32'h00000002);
        wr(`EEE_IDX_PCS_LPI_STATUS, 16'hffff);
        expect_reg("status ro", `EEE_IDX_PCS_LPI_STATUS, 32'h00000040);
        adv_strap <= 1'b0;
        wr(`EEE_IDX_PCS_CTRL, 16'h8000);
        idle(2);
        expect_reg("adv strap", `EEE_IDX_LOCAL_ADV, 32'h00000000);
        adv_strap <= 1'b1;
        wr(`EEE_IDX_LOCAL_ADV, 16'h0002);
        wr(`EEE_IDX_EEE_CFG, 16'h0000);
        idle(2);
        check("negotiation off", {31'h0, eee_negotiation_on}, 32'h0);
        check("adv gated", {31'h0, advertise_eee_100}, 32'h0);
        wr(`EEE_IDX_EEE_CFG, 16'h0001);
        idle(2);
        check("adv on", {31'h0, advertise_eee_100}, 32'h1);
        $display("test advertise done");
    endtask

    task automatic test_partner();
        @(posedge clock);
        p_req <= 1'b1;
        idle(6);
        expect_reg("partner on", `EEE_IDX_PARTNER_ABILITY, 32'h00000002);
        p_req <= 1'b0;
        idle(6);
        expect_reg("partner off", `EEE_IDX_PARTNER_ABILITY, 32'h00000000);
        $display("test partner done");
    endtask

    // reset in mid-run: outputs while held, state and strap after release
    task automatic test_mid_reset();
        faults(8'h01);
        @(posedge clock);
        resetn <= 1'b0;
        idle(2);
        check("wait in reset", {31'h0, avs_waitrequest}, 32'h1);
        check("adv in reset", {31'h0, advertise_eee_100}, 32'h0);
        check("neg in reset", {31'h0, eee_negotiation_on}, 32'h0);
        check("stop in reset", {31'h0, tx_clock_stoppable}, 32'h1);
        resetn <= 1'b1;
        idle(2);
        expect_reg("count after reset", `EEE_IDX_WAKE_FAULT, 32'h00000000);
        expect_reg("irq after reset", `EEE_IDX_IRQ_STATUS, 32'h00000000);
        check("adv after reset", {31'h0, advertise_eee_100}, 32'h1);
        $display("test mid reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        idle(2);
        resetn <= 1'b1;
        idle(2);
        test_reset_values();
        test_lpi_and_irq();
        test_wake_counter();
        test_advertise();
        test_partner();
        test_mid_reset();
        print_verdict();
    end
endmodule // eee_lpi_status_registers_tb
